// File: rtl/frt_link_if.sv
/*
 * Word handshake between the master-clock sequencer and the link-clock serializer.
 * Assumes word, bit12 and lanes stay stable while req differs from ack (toggle handshake).
 */
`default_nettype none

interface frt_link_if;
   logic [frt_pkg::WORD_W-1:0] word;
   logic bit12;
   logic [frt_pkg::MAX_LANES-1:0] lanes;
   logic req;
   logic ack;
   modport seq (output word, output bit12, output lanes, output req, input ack);
   modport lnk (input word, input bit12, input lanes, input req, output ack);
endinterface : frt_link_if

`default_nettype wire

// File: rtl/frt_pkg.sv
/*
 * Shared constants and types for the frame readout timing block:
 * register addresses, reset values, readout unit length and state encoding.
 * Assumes the master clock domain is clock_i and the link side uses its own clock.
 */
`default_nettype none

package frt_pkg;
   // register map, 7-bit register index
   localparam logic [6:0] FOT_LEN_ADDR = 7'h49;
   localparam logic [7:0] FOT_LEN_RESET = 8'h14;
   localparam logic [6:0] STATUS_ADDR = 7'h7a;

   // one readout unit is 129 master clock periods
   localparam int unsigned UNIT_CYCLES = 129;
   localparam logic [7:0] UNIT_LAST = 8'h80;

   // serial link shape
   localparam int unsigned MAX_LANES = 16;
   localparam int unsigned WORD_W = 12;
   localparam int unsigned WORD10_W = 10;
   localparam logic [3:0] LAST_BIT_10 = 4'h9;
   localparam logic [3:0] LAST_BIT_12 = 4'hb;

   // fast clock to master clock ratio per bit mode
   localparam logic [3:0] RATIO_10 = 4'ha;
   localparam logic [3:0] RATIO_12 = 4'hc;

   typedef enum logic [1:0] {ST_IDLE, ST_FOT, ST_LINES, ST_WAIT} frt_state_e;
endpackage : frt_pkg

`default_nettype wire

// File: rtl/frt_readout_top.sv
/*
 * Frame readout sequencer: on a frame request it times the frame overhead and the
 * line readout intervals in master clock units, hands one word per line (dropped if the serializer is still busy) to the
 * link-clock serializer and holds the frame period to the longer of readout and exposure.
 * Assumes configuration inputs come from logic on clock_i and frame_req_i is an async pin.
 */
// Operation
// (R1) Master clock is one tenth (10-bit) or one twelfth (12-bit) of fast clock.
// (R2) Per-lane rate equals fast clock, at most 480Mbps; master clock 48 or 40MHz.
// (R3) Works for master clock 5MHz to max and fast clock 50MHz to max.
// (R4) Exposure runs during readout; short exposure leaves frame period set by readout.
// (R5) Readout depends on clock, bit mode, lines and lanes; at most 16 lanes.
// (R6) Total readout period is frame overhead then image readout, back to back.
// (R7) Overhead lasts (overhead length + 2*16/lanes) * 129 master clocks.
// (R8) Overhead length register at index 73, reset value 20.
// (R9) Each line lasts 129 * 16/lanes master clocks, times the line count.
// (R10) Default is full-resolution 10-bit readout through 16 lanes.
// (R11) High frame request on a clock edge starts the programmed number of frames.
// (R12) Exposure longer than readout governs the frame period.
// (R13) Lanes in use must divide 16 evenly.
// (R14) Sequencer counts master clocks; next frame only after the previous period ends.
`default_nettype none

module frt_readout_top (
   // master clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // link clock
   input wire logic link_clk_i,
   // frame request pin
   input wire logic frame_req_i,
   // readout configuration
   input wire logic [4:0] outputs_used_i,
   input wire logic [10:0] lines_i,
   input wire logic bit_mode_12_i,
   input wire logic [15:0] frames_i,
   input wire logic [23:0] exposure_cycles_i,
   // register port
   input wire logic reg_we_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // status
   output logic readout_busy_o,
   output logic fot_active_o,
   output logic frame_done_o,
   output logic overrun_o,
   output logic [3:0] clk_ratio_o,
   // serial link pins
   output logic [frt_pkg::MAX_LANES-1:0] pixel_serial_outputs_o,
   output logic output_serial_clock_o,
   output logic output_control_channel_o
);
   typedef struct packed {
      frt_pkg::frt_state_e st;
      logic req_s1;
      logic req_s2;
      logic ack_s1;
      logic ack_s2;
      logic [7:0] fot_len;
      logic [7:0] rdata;
      logic [7:0] unit_cyc;
      logic [8:0] unit_cnt;
      logic [10:0] line_cnt;
      logic [15:0] frames_left;
      logic [23:0] exp_cnt;
      logic [4:0] factor;
      logic bit12;
      logic [frt_pkg::MAX_LANES-1:0] lanes;
      logic [frt_pkg::WORD_W-1:0] word;
      logic req_tgl;
      logic frame_done;
      logic overrun;
   } frt_seq_s;

   // default run: 10-bit mode, overhead length 20
   localparam frt_seq_s SEQ_RESET = '{st: frt_pkg::ST_IDLE, fot_len: frt_pkg::FOT_LEN_RESET, default: '0}; // [R10]

   // 16 / lanes in use; lane counts that do not divide 16 fall back to one unit
   function automatic logic [4:0] lane_factor(input logic [4:0] n);
      unique case (n)
         5'h01: lane_factor = 5'h10;
         5'h02: lane_factor = 5'h08;
         5'h04: lane_factor = 5'h04;
         5'h08: lane_factor = 5'h02;
         default: lane_factor = 5'h01;
      endcase
   endfunction : lane_factor

   function automatic logic [frt_pkg::MAX_LANES-1:0] lane_mask(input logic [4:0] n);
      lane_mask = frt_pkg::MAX_LANES'((32'h1 << n) - 32'h1);
   endfunction : lane_mask

   frt_seq_s q;
   frt_seq_s d;
   logic unit_end;
   logic line_end;
   logic [8:0] fot_units;
   logic run_start;
   logic [7:0] status;

   frt_link_if link_if ();

   assign unit_end = (q.unit_cyc == frt_pkg::UNIT_LAST);
   assign fot_units = 9'(q.fot_len) + 9'({q.factor, 1'b0}); // [R7]
   assign line_end = (q.st == frt_pkg::ST_LINES) && unit_end && (q.unit_cnt + 9'h1 == 9'(q.factor)); // [R9]
   assign run_start = (q.st == frt_pkg::ST_IDLE) && q.req_s2 && (frames_i != '0) && (lines_i != '0);
   assign status = {3'b000, q.overrun, q.st == frt_pkg::ST_WAIT, q.st == frt_pkg::ST_LINES,
                    q.st == frt_pkg::ST_FOT, q.st != frt_pkg::ST_IDLE};

   always_comb begin
      d = q;
      d.frame_done = 1'b0;
      d.req_s1 = frame_req_i;
      d.req_s2 = q.req_s1;
      d.ack_s1 = link_if.ack;
      d.ack_s2 = q.ack_s1;
      // a new overhead length is used from the next overhead unit boundary on
      if (reg_we_i && reg_addr_i == frt_pkg::FOT_LEN_ADDR) begin // [R8]
         d.fot_len = reg_wdata_i;
      end
      if (reg_addr_i == frt_pkg::FOT_LEN_ADDR) begin
         d.rdata = q.fot_len;
      end else if (reg_addr_i == frt_pkg::STATUS_ADDR) begin
         d.rdata = status;
      end else begin
         d.rdata = '0;
      end
      // exposure runs alongside the readout and saturates instead of wrapping
      if (q.st != frt_pkg::ST_IDLE && q.exp_cnt != '1) begin // [R4]
         d.exp_cnt = q.exp_cnt + 24'h1;
      end
      if (q.st == frt_pkg::ST_FOT || q.st == frt_pkg::ST_LINES) begin // [R14]
         d.unit_cyc = unit_end ? '0 : q.unit_cyc + 8'h1;
      end
      unique case (q.st)
         frt_pkg::ST_IDLE: begin
            if (run_start) begin // [R11]
               d.st = frt_pkg::ST_FOT;
               d.frames_left = q.frames_left;
               d.frames_left = frames_i - 16'h1;
               d.factor = lane_factor(outputs_used_i); // [R5]
               d.lanes = lane_mask(outputs_used_i);
               d.bit12 = bit_mode_12_i;
               d.overrun = 1'b0;
               d.unit_cyc = '0;
               d.unit_cnt = '0;
               d.exp_cnt = '0;
            end
         end
         frt_pkg::ST_FOT: begin
            if (unit_end) begin
               if (q.unit_cnt + 9'h1 == fot_units) begin // [R7]
                  d.st = frt_pkg::ST_LINES; // [R6]
                  d.unit_cnt = '0;
                  d.line_cnt = '0;
               end else begin
                  d.unit_cnt = q.unit_cnt + 9'h1;
               end
            end
         end
         frt_pkg::ST_LINES: begin
            if (line_end) begin // [R9]
               d.unit_cnt = '0;
               // the serializer is slower than a line at low link rates: drop and flag
               if (q.req_tgl != q.ack_s2) begin
                  d.overrun = 1'b1;
               end else begin
                  d.word = {1'b0, q.line_cnt};
                  d.req_tgl = ~q.req_tgl;
               end
               if (q.line_cnt + 11'h1 == lines_i) begin
                  d.st = frt_pkg::ST_WAIT;
               end else begin
                  d.line_cnt = q.line_cnt + 11'h1;
               end
            end else if (unit_end) begin
               d.unit_cnt = q.unit_cnt + 9'h1;
            end
         end
         frt_pkg::ST_WAIT: begin
            // a long exposure stretches the frame beyond the readout
            if (q.exp_cnt >= exposure_cycles_i) begin // [R12]
               d.frame_done = 1'b1;
               if (q.frames_left != '0) begin // [R14]
                  d.frames_left = q.frames_left - 16'h1;
                  d.st = frt_pkg::ST_FOT;
                  d.unit_cyc = '0;
                  d.unit_cnt = '0;
                  d.exp_cnt = '0;
               end else begin
                  d.st = frt_pkg::ST_IDLE;
               end
            end
         end
      endcase
      if (rst_i) begin
         d = SEQ_RESET;
      end
   end

   always_ff @(posedge clock_i) begin
      q <= d;
   end

   assign link_if.word = q.word;
   assign link_if.bit12 = q.bit12;
   assign link_if.lanes = q.lanes;
   assign link_if.req = q.req_tgl;

   assign reg_rdata_o = q.rdata;
   assign readout_busy_o = (q.st != frt_pkg::ST_IDLE);
   assign fot_active_o = (q.st == frt_pkg::ST_FOT);
   assign frame_done_o = q.frame_done;
   assign overrun_o = q.overrun;
   // the fast clock the far end must supply, relative to the master clock
   assign clk_ratio_o = q.bit12 ? frt_pkg::RATIO_12 : frt_pkg::RATIO_10; // [R1] [R2] [R3]

   frt_serializer u_ser (
      .link_clk_i(link_clk_i),
      .rst_i(rst_i),
      .link(link_if.lnk),
      .pixel_serial_outputs_o(pixel_serial_outputs_o),
      .output_serial_clock_o(output_serial_clock_o),
      .output_control_channel_o(output_control_channel_o)
   );

   // interval counters read only by the checks below
   int fot_cyc_q;
   int line_cyc_q;
   always_ff @(posedge clock_i) begin
      if (rst_i || q.st != frt_pkg::ST_FOT) begin
         fot_cyc_q <= 0;
      end else begin
         fot_cyc_q <= fot_cyc_q + 1;
      end
      if (rst_i || q.st != frt_pkg::ST_LINES || line_end) begin
         line_cyc_q <= 0;
      end else begin
         line_cyc_q <= line_cyc_q + 1;
      end
   end

   a_fot_reset: assert property (@(posedge clock_i) rst_i |=> q.fot_len == frt_pkg::FOT_LEN_RESET) // [R8]
      else $error("overhead length not back at its reset value");

   a_fot_length: assert property (@(posedge clock_i) disable iff (rst_i) // [R7]
      (q.st == frt_pkg::ST_FOT && d.st == frt_pkg::ST_LINES) |->
      (fot_cyc_q + 1 == int'(fot_units) * frt_pkg::UNIT_CYCLES))
      else $error("frame overhead length wrong");

   a_line_time: assert property (@(posedge clock_i) disable iff (rst_i) // [R9]
      line_end |-> (line_cyc_q + 1 == int'(q.factor) * frt_pkg::UNIT_CYCLES))
      else $error("line readout time wrong");

   a_back_to_back: assert property (@(posedge clock_i) disable iff (rst_i) // [R6]
      $rose(q.st == frt_pkg::ST_LINES) |-> $past(q.st) == frt_pkg::ST_FOT)
      else $error("image readout did not follow the overhead");

   a_exposure_gate: assert property (@(posedge clock_i) disable iff (rst_i) // [R12]
      (q.st == frt_pkg::ST_WAIT && d.st != frt_pkg::ST_WAIT) |-> q.exp_cnt >= exposure_cycles_i)
      else $error("frame ended before exposure");

   a_short_exposure: assert property (@(posedge clock_i) disable iff (rst_i) // [R4]
      (q.st == frt_pkg::ST_WAIT && q.exp_cnt >= exposure_cycles_i) |=> q.frame_done)
      else $error("short exposure delayed the frame");

   a_request_start: assert property (@(posedge clock_i) disable iff (rst_i) // [R11]
      run_start |=> (q.st == frt_pkg::ST_FOT && q.frames_left == $past(frames_i) - 16'h1))
      else $error("frame request did not start a run");

   a_frame_spacing: assert property (@(posedge clock_i) disable iff (rst_i) // [R14]
      (q.st != frt_pkg::ST_FOT ##1 q.st == frt_pkg::ST_FOT) |->
      ($past(q.st) == frt_pkg::ST_IDLE || q.frame_done))
      else $error("overhead started before the previous frame ended");

   a_lane_factor: assert property (@(posedge clock_i) disable iff (rst_i) // [R5]
      (run_start && $onehot(outputs_used_i)) |=>
      (int'(q.factor) * int'($past(outputs_used_i)) == frt_pkg::MAX_LANES))
      else $error("lane factor does not match lanes in use");

   c_frame_done: cover property (@(posedge clock_i) disable iff (rst_i) q.frame_done);
   c_next_frame: cover property (@(posedge clock_i) disable iff (rst_i)
      q.frame_done ##0 q.st == frt_pkg::ST_FOT);
   c_long_exposure: cover property (@(posedge clock_i) disable iff (rst_i)
      (q.st == frt_pkg::ST_WAIT) [*8]);
   c_overrun: cover property (@(posedge clock_i) disable iff (rst_i) $rose(q.overrun));
endmodule : frt_readout_top

`default_nettype wire

// File: rtl/frt_serializer.sv
/*
 * Link-clock serializer: takes one word per toggle request and shifts it MSB first
 * onto every enabled serial lane, with a control flag framing the word.
 * Assumes link_clk_i may be unrelated to the master clock; rst_i is resynchronised here.
 */
`default_nettype none

module frt_serializer (
   // link clock and master-domain reset
   input wire logic link_clk_i,
   input wire logic rst_i,
   // word handshake
   frt_link_if.lnk link,
   // serial pins
   output logic [frt_pkg::MAX_LANES-1:0] pixel_serial_outputs_o,
   output logic output_serial_clock_o,
   output logic output_control_channel_o
);
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic req_s1;
      logic req_s2;
      logic ack;
      logic active;
      logic ctrl;
      logic sclk;
      logic [3:0] bit_idx;
      logic [frt_pkg::WORD_W-1:0] shreg;
      logic [frt_pkg::MAX_LANES-1:0] lanes;
      logic [frt_pkg::MAX_LANES-1:0] dout;
   } frt_ser_s;

   frt_ser_s q;
   frt_ser_s d;

   always_comb begin
      d = q;
      d.rst_s1 = rst_i;
      d.rst_s2 = q.rst_s1;
      d.req_s1 = link.req;
      d.req_s2 = q.req_s1;
      d.sclk = ~q.sclk;
      d.ctrl = q.active;
      if (q.active) begin
         d.dout = q.lanes & {frt_pkg::MAX_LANES{q.shreg[frt_pkg::WORD_W-1]}};
         d.shreg = {q.shreg[frt_pkg::WORD_W-2:0], 1'b0};
         if (q.bit_idx == '0) begin
            d.active = 1'b0;
            d.ack = ~q.ack;
         end else begin
            d.bit_idx = q.bit_idx - 4'h1;
         end
      end else begin
         d.dout = '0;
         // word length follows the converter bit mode
         if (q.req_s2 != q.ack) begin // [R5]
            d.active = 1'b1;
            d.lanes = link.lanes;
            d.bit_idx = link.bit12 ? frt_pkg::LAST_BIT_12 : frt_pkg::LAST_BIT_10;
            d.shreg = link.bit12 ? link.word :
               {link.word[frt_pkg::WORD10_W-1:0], {(frt_pkg::WORD_W-frt_pkg::WORD10_W){1'b0}}};
         end
      end
      if (q.rst_s2) begin
         d.ack = 1'b0;
         d.active = 1'b0;
         d.ctrl = 1'b0;
         d.sclk = 1'b0;
         d.bit_idx = '0;
         d.shreg = '0;
         d.lanes = '0;
         d.dout = '0;
      end
   end

   always_ff @(posedge link_clk_i) begin
      q <= d;
   end

   assign link.ack = q.ack;
   assign pixel_serial_outputs_o = q.dout;
   assign output_serial_clock_o = q.sclk;
   assign output_control_channel_o = q.ctrl;

   a_word_length: assert property (@(posedge link_clk_i) disable iff (q.rst_s2) // [R5]
      (!q.active && q.req_s2 != q.ack) |=>
      (q.active && q.bit_idx == ($past(link.bit12) ? frt_pkg::LAST_BIT_12 : frt_pkg::LAST_BIT_10)))
      else $error("serial word length does not match bit mode");

   // run length of the control flag, read only by the check below
   logic [3:0] ctrl_run_q;
   always_ff @(posedge link_clk_i) begin
      if (q.rst_s2 || !q.ctrl) begin
         ctrl_run_q <= '0;
      end else begin
         ctrl_run_q <= ctrl_run_q + 4'h1;
      end
   end

   a_ctrl_span: assert property (@(posedge link_clk_i) disable iff (q.rst_s2) // [R5]
      $fell(output_control_channel_o) |->
      (ctrl_run_q == 4'(frt_pkg::WORD10_W) || ctrl_run_q == 4'(frt_pkg::WORD_W)))
      else $error("control flag does not span exactly one word");

   c_word_12: cover property (@(posedge link_clk_i) disable iff (q.rst_s2)
      (q.active && q.bit_idx == frt_pkg::LAST_BIT_12));
endmodule : frt_serializer

`default_nettype wire

// File: sim/frt_rx_model.sv
/*
 * Receiving camera logic: collects the words framed by the control channel on
 * the serial lanes, MSB first, and counts bit periods in which any lane in use disagrees with lane 0.
 * Assumes the link clock is the fast clock that the camera side also feeds the block.
 */
`default_nettype none

module frt_rx_model (
   // link clock and bench reset
   input wire logic link_clk_i,
   input wire logic rst_i,
   // serial pins and lanes in use
   input wire logic [15:0] pixel_serial_outputs_i,
   input wire logic output_control_channel_i,
   input wire logic [4:0] lanes_i,
   // collected words
   output logic [11:0] word_o,
   output logic [4:0] bits_o,
   output logic [15:0] count_o,
   output logic [15:0] lane_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] shift_q;
   logic [4:0] n_q;
   logic [15:0] mask;

   // only the low lanes in use carry data
   assign mask = (lanes_i >= 5'h10) ? 16'hffff : ((16'h0001 << lanes_i) - 16'h0001);

   always @(posedge link_clk_i) begin
      if (rst_i) begin
         shift_q <= 12'h000;
         n_q <= 5'h00;
         word_o <= 12'h000;
         bits_o <= 5'h00;
         count_o <= 16'h0000;
         lane_err_o <= 16'h0000;
      end else if (output_control_channel_i) begin
         // msb arrives first
         shift_q <= {shift_q[10:0], pixel_serial_outputs_i[0]};
         n_q <= n_q + 5'h01;
         if ((pixel_serial_outputs_i & mask) != (pixel_serial_outputs_i[0] ? mask : 16'h0000)) begin
            lane_err_o <= lane_err_o + 16'h0001;
         end
      end else if (n_q != 5'h00) begin
         word_o <= shift_q;
         bits_o <= n_q;
         count_o <= count_o + 16'h0001;
         n_q <= 5'h00;
         shift_q <= 12'h000;
      end
   end
endmodule : frt_rx_model

`default_nettype wire

// File: sim/tb_frame_readout_timing.sv
/*
 * Testbench for the frame readout timing block: register port, overhead and line
 * timing per lane count and bit mode, exposure-bound frames, overrun and link words.
 * Assumes the design package and link interface are compiled first.
 */
`default_nettype none

module tb_frame_readout_timing;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 0, link_clk = 0, rst_i = 1, frame_req = 0, b12 = 0, we = 0;
   logic [4:0] lanes = 5'h10;
   logic [10:0] lines = 11'h001;
   logic [15:0] frames = 16'h0001;
   logic [23:0] expo = 24'h00_0000;
   logic [6:0] addr = 7'h00;
   logic [7:0] wdata = 8'h00, rdata, v;
   logic busy, fot, done, ovr, ctrl, sclk;
   logic [3:0] ratio;
   logic [15:0] pix, rx_count, rx_err, base;
   logic [11:0] rx_word;
   logic [4:0] rx_bits;
   int fails = 0, compares = 0, cycles = 0;
   int fot_n, rd_n, dones;

   always #2.5 clock_i = ~clock_i;
   // fast clock free-running, phase unrelated to the master clock
   initial begin
      #17;
      forever #62.5 link_clk = ~link_clk;
   end

   frt_readout_top i_frt_readout_top (.clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk),
      .frame_req_i(frame_req), .outputs_used_i(lanes), .lines_i(lines), .bit_mode_12_i(b12),
      .frames_i(frames), .exposure_cycles_i(expo), .reg_we_i(we), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .readout_busy_o(busy), .fot_active_o(fot),
      .frame_done_o(done), .overrun_o(ovr), .clk_ratio_o(ratio), .pixel_serial_outputs_o(pix),
      .output_serial_clock_o(sclk), .output_control_channel_o(ctrl));

   frt_rx_model i_frt_rx_model (.link_clk_i(link_clk), .rst_i(rst_i), .pixel_serial_outputs_i(pix),
      .output_control_channel_i(ctrl), .lanes_i(lanes), .word_o(rx_word), .bits_o(rx_bits),
      .count_o(rx_count), .lane_err_o(rx_err));

   task automatic tally_and_finish;
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic near(input int seen, input int lo, input int slack);
      check(32'(seen >= lo && seen <= lo + slack), 32'h0000_0001);
   endtask : near

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick

   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      we = 1;
      tick(1);
      we = 0;
      tick(1);
   endtask : reg_write

   task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
      addr = a;
      tick(2);
      d = rdata;
   endtask : reg_read

   // one request; measures overhead, line time to first done, and done pulses
   task automatic run(input logic [4:0] ln, input logic [10:0] nl, input logic m12,
                      input logic [15:0] nf, input logic [23:0] ex);
      int t;
      lanes = ln;
      lines = nl;
      b12 = m12;
      frames = nf;
      expo = ex;
      base = rx_count;
      frame_req = 1;
      t = 0;
      while (fot !== 1'b1 && t < 10) begin
         tick(1);
         t++;
      end
      frame_req = 0;
      check(t, 3);
      fot_n = 0;
      while (fot === 1'b1 && fot_n < 20000) begin
         tick(1);
         fot_n++;
      end
      rd_n = 0;
      while (done !== 1'b1 && rd_n < 30000) begin
         tick(1);
         rd_n++;
      end
      dones = 1;
      t = 0;
      while (busy === 1'b1 && t < 30000) begin
         tick(1);
         t++;
         if (done === 1'b1) dones++;
      end
      // let the last word leave the link
      tick(600);
   endtask : run

   initial begin
      tick(100);
      rst_i = 0;
      tick(2);
      reg_read(frt_pkg::FOT_LEN_ADDR, v);
      check(v, frt_pkg::FOT_LEN_RESET);
      check(ratio, 4'ha);
      check(busy, 1'b0);
      reg_write(7'h10, 8'hff);
      reg_write(frt_pkg::FOT_LEN_ADDR, 8'h05);
      reg_read(frt_pkg::FOT_LEN_ADDR, v);
      check(v, 8'h05);
      reg_read(7'h10, v);
      check(v, 8'h00);
      // 10-bit, one lane, two lines: short exposure leaves readout in charge
      run(5'h01, 11'h002, 1'b0, 16'h0001, 24'h00_0010);
      check(fot_n, (5 + 32) * 129);
      near(rd_n, 2 * 2064 - 1, 4);
      check(dones, 1);
      check(ratio, 4'ha);
      check(rx_count - base, 16'h0002);
      check(rx_word, 12'h001);
      check(rx_bits, 5'h0a);
      check(ovr, 1'b0);
      // output clock runs at half the fast clock: one link period inverts it
      v[0] = sclk;
      #125;
      check(32'(sclk ^ v[0]), 32'h0000_0001);
      // 12-bit, two lanes, two frames back to back
      run(5'h02, 11'h001, 1'b1, 16'h0002, 24'h00_0010);
      check(fot_n, (5 + 16) * 129);
      near(rd_n, 1032 - 1, 4);
      check(dones, 2);
      check(ratio, 4'hc);
      check(rx_count - base, 16'h0002);
      check(rx_word, 12'h000);
      check(rx_bits, 5'h0c);
      // four lanes, exposure far beyond readout sets the frame period
      run(5'h04, 11'h001, 1'b0, 16'h0001, 24'h00_4e20);
      check(fot_n, (5 + 8) * 129);
      near(fot_n + rd_n, 19999, 4);
      // sixteen lanes at reset length: lines outrun the link and a word is dropped
      reg_write(frt_pkg::FOT_LEN_ADDR, 8'h14);
      run(5'h10, 11'h002, 1'b0, 16'h0001, 24'h00_0010);
      check(fot_n, (20 + 2) * 129);
      near(rd_n, 2 * 129 - 1, 4);
      check(ovr, 1'b1);
      reg_read(frt_pkg::STATUS_ADDR, v);
      check(v, 8'h10);
      // eight lanes, one line: the overrun of the last run is cleared at the start
      run(5'h08, 11'h001, 1'b0, 16'h0001, 24'h00_0010);
      check(fot_n, (20 + 4) * 129);
      near(rd_n, 2 * 129 - 1, 4);
      check(ovr, 1'b0);
      check(rx_err, 16'h0000);
      tally_and_finish();
   end
endmodule : tb_frame_readout_timing

`default_nettype wire
